// ### pkg/dcd_pkg.sv
/*
  package for the ddr2 command and clock-enable decoder: command encodings,
  device states, mode register layout, timing counts.
  assumes a single 40 MHz system clock; the memory clock is sampled as data.
*/
package dcd_pkg;

  // -------------------------------------------------------------------------
  // widths and counts
  // -------------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 14;
  localparam int unsigned BANK_W       = 2;
  localparam int unsigned NUM_BANKS    = 4;
  localparam int unsigned BURST_LEN    = 4;
  localparam int unsigned BURST_CLKS   = BURST_LEN / 2;
  localparam int unsigned AP_BIT       = 10;
  localparam int unsigned ODT_A2_BIT   = 2;
  localparam int unsigned ODT_A6_BIT   = 6;
  localparam int unsigned PD_EXIT_BIT  = 12;
  localparam int unsigned SR_EXIT_READ_CLKS = 200;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;

  // -------------------------------------------------------------------------
  // decoded commands and device states
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_MODE_WRITE, CMD_REFRESH, CMD_ACTIVATE,
    CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_ILLEGAL
  } dcd_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACTIVE, ST_ACT_PD, ST_PRE_PD, ST_SELF_REF
  } dcd_state_t;

  // sampled command pins travel together
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic              odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dcd_pins_t;

endpackage : dcd_pkg

// ### logic/dcd_decoder.sv
/*
  ddr2 command decoder and clock-enable state logic.
  assumes the controller honours command spacing and clock-enable minimum
  widths; the memory clock and all pins are asynchronous to I_CLK.
*/
// Notes on behaviour
// - commands decoded from pins at clock rise
// - mode write both bank bits low: base
// - bank0 high bank1 low: extended one
// - bank0 low bank1 high: extended two
// - activate read write precharge encodings, A10
// - bank commands act only on named bank, except precharge with A10 high, which closes all banks
// - four-beat bursts always run to completion
// - no internal refresh during power down
// - termination ignored; unavailable in self refresh
// - self refresh left on clock-enable rise
// - open bank plus cke fall: active powerdown
// - idle banks plus cke fall: precharge powerdown
// - self refresh entry only when idle
// - transitions judged from current and previous cke
// - unlisted combinations are undefined
// - mode bit A12 picks active powerdown exit type; precharge powerdown always turns the dll off
`timescale 1ns/1ps

module dcd_decoder (
  // system
  input  wire logic                         I_CLK,
  input  wire logic                         I_SYS_RST,
  // memory pins
  input  wire logic                         I_MEM_CK,
  input  wire logic                         I_CKE,
  input  wire logic                         I_CS_N,
  input  wire logic                         I_RAS_N,
  input  wire logic                         I_CAS_N,
  input  wire logic                         I_WE_N,
  input  wire logic                         I_ODT,
  input  wire logic [dcd_pkg::BANK_W-1:0]   I_BA,
  input  wire logic [dcd_pkg::ADDR_W-1:0]   I_ADDR,
  // mode registers
  output logic      [dcd_pkg::ADDR_W-1:0]   O_MODE_REG,
  output logic      [dcd_pkg::ADDR_W-1:0]   O_EXT_MODE_ONE,
  output logic      [dcd_pkg::ADDR_W-1:0]   O_EXT_MODE_TWO,
  // state
  output logic      [2:0]                   O_STATE,
  output logic      [dcd_pkg::NUM_BANKS-1:0] O_BANK_OPEN,
  output logic      [dcd_pkg::ADDR_W-1:0]   O_ROW_ADDR,
  output logic                              O_BURST_BUSY,
  output logic                              O_BURST_WRITE,
  output logic      [dcd_pkg::BANK_W-1:0]   O_BURST_BANK,
  output logic                              O_REFRESH_PULSE,
  output logic                              O_INTERNAL_REFRESH_EN,
  output logic                              O_ODT_AVAIL,
  output logic                              O_DLL_ON,
  output logic                              O_READ_ALLOWED
);

  // -------------------------------------------------------------------------
  // synchronisers: two flops on every pin before any logic looks at it
  // -------------------------------------------------------------------------
  dcd_pkg::dcd_pins_t pins_meta_r;
  dcd_pkg::dcd_pins_t pins_r;
  dcd_pkg::dcd_pins_t pins_d_r;
  logic               ck_meta_r;
  logic               ck_r;
  logic               ck_d_r;
  dcd_pkg::dcd_pins_t pins_raw;

  assign pins_raw = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_CKE, I_ODT, I_BA, I_ADDR};

  // pins_d_r is one more stage so the pins line up with the clock edge found
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pins_meta_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      pins_r      <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      pins_d_r    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      ck_meta_r   <= 1'b0;
      ck_r        <= 1'b0;
      ck_d_r      <= 1'b0;
    end else begin
      pins_meta_r <= pins_raw;
      pins_r      <= pins_meta_r;
      pins_d_r    <= pins_r;
      ck_meta_r   <= I_MEM_CK;
      ck_r        <= ck_meta_r;
      ck_d_r      <= ck_r;
    end
  end

  // -------------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------------
  // pins are sampled the cycle before the clock rise is seen, i.e. the
  // levels that stood at the edge; holds only for slow memory clocks
  wire ck_rise = ck_r & ~ck_d_r;
  dcd_pkg::dcd_pins_t p;
  assign p = pins_d_r;

  function automatic dcd_pkg::dcd_cmd_t decode(input dcd_pkg::dcd_pins_t s);
    dcd_pkg::dcd_cmd_t c;
    c = dcd_pkg::CMD_ILLEGAL;
    if (s.cs_n)                                            c = dcd_pkg::CMD_DESELECT;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b111)         c = dcd_pkg::CMD_NOP;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b000)         c = dcd_pkg::CMD_MODE_WRITE;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b001)         c = dcd_pkg::CMD_REFRESH;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b011)         c = dcd_pkg::CMD_ACTIVATE;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b101)         c = dcd_pkg::CMD_READ;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b100)         c = dcd_pkg::CMD_WRITE;
    else if ({s.ras_n, s.cas_n, s.we_n} == 3'b010)         c = dcd_pkg::CMD_PRECHARGE;
    return c;
  endfunction

  // odt is carried but never enters decode
  dcd_pkg::dcd_cmd_t cmd;
  assign cmd = decode(p);

  // -------------------------------------------------------------------------
  // state decode from previous and current clock-enable
  // -------------------------------------------------------------------------
  dcd_pkg::dcd_state_t state_r;
  dcd_pkg::dcd_state_t state_nxt;
  logic                cke_prev_r;
  logic [dcd_pkg::NUM_BANKS-1:0] bank_open_r;
  logic [1:0]          burst_cnt_r;
  logic [7:0]          sr_exit_cnt_r;

  wire in_sr     = (state_r == dcd_pkg::ST_SELF_REF);
  wire quiet     = (cmd == dcd_pkg::CMD_DESELECT) || (cmd == dcd_pkg::CMD_NOP);
  wire all_idle  = (bank_open_r == '0);
  wire both_hi   = cke_prev_r & p.cke;
  wire cke_fall  = cke_prev_r & ~p.cke;
  wire cke_rise  = ~cke_prev_r & p.cke;
  wire exec      = ck_rise & both_hi & ~in_sr;
  wire [dcd_pkg::NUM_BANKS-1:0] ba_hot = dcd_pkg::NUM_BANKS'(1) << p.ba;

  // self-refresh exit does not need a memory clock edge
  wire sr_exit   = in_sr & p.cke;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dcd_pkg::ST_IDLE, dcd_pkg::ST_ACTIVE: begin
        if (ck_rise && cke_fall && quiet) begin
          state_nxt = all_idle ? dcd_pkg::ST_PRE_PD : dcd_pkg::ST_ACT_PD;
        end else if (ck_rise && cke_fall && cmd == dcd_pkg::CMD_REFRESH && all_idle) begin
          state_nxt = dcd_pkg::ST_SELF_REF;
        end else begin
          state_nxt = all_idle ? dcd_pkg::ST_IDLE : dcd_pkg::ST_ACTIVE;
        end
      end
      dcd_pkg::ST_ACT_PD: begin
        if (ck_rise && cke_rise) state_nxt = dcd_pkg::ST_ACTIVE;
      end
      dcd_pkg::ST_PRE_PD: begin
        if (ck_rise && cke_rise) state_nxt = dcd_pkg::ST_IDLE;
      end
      dcd_pkg::ST_SELF_REF: begin
        if (sr_exit) state_nxt = dcd_pkg::ST_IDLE;
      end
      default: state_nxt = dcd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_r    <= dcd_pkg::ST_IDLE;
      cke_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (ck_rise || sr_exit) cke_prev_r <= p.cke;
    end
  end

  // -------------------------------------------------------------------------
  // mode registers
  // -------------------------------------------------------------------------
  wire mode_wr = exec && cmd == dcd_pkg::CMD_MODE_WRITE;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_MODE_REG     <= dcd_pkg::MODE_RST;
      O_EXT_MODE_ONE <= dcd_pkg::MODE_RST;
      O_EXT_MODE_TWO <= dcd_pkg::MODE_RST;
    end else if (mode_wr) begin
      if (p.ba == 2'b00) O_MODE_REG     <= p.addr;
      if (p.ba == 2'b01) O_EXT_MODE_ONE <= p.addr;
      if (p.ba == 2'b10) O_EXT_MODE_TWO <= p.addr;
    end
  end

  // -------------------------------------------------------------------------
  // bank and burst tracking
  // -------------------------------------------------------------------------
  wire burst_busy = (burst_cnt_r != 2'd0);
  wire rw_cmd     = exec && (cmd == dcd_pkg::CMD_READ || cmd == dcd_pkg::CMD_WRITE);
  wire pre_cmd    = exec && cmd == dcd_pkg::CMD_PRECHARGE;
  wire act_cmd    = exec && cmd == dcd_pkg::CMD_ACTIVATE;

  // new burst only starts when previous one is done, so none is truncated
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bank_open_r   <= '0;
      O_ROW_ADDR    <= '0;
      burst_cnt_r   <= 2'd0;
      O_BURST_WRITE <= 1'b0;
      O_BURST_BANK  <= '0;
    end else begin
      if (act_cmd) begin
        bank_open_r <= bank_open_r | ba_hot;
        O_ROW_ADDR  <= p.addr;
      end else if (pre_cmd) begin
        bank_open_r <= p.addr[dcd_pkg::AP_BIT] ? '0 : (bank_open_r & ~ba_hot);
      end else if (rw_cmd && !burst_busy && p.addr[dcd_pkg::AP_BIT]) begin
        bank_open_r <= bank_open_r & ~ba_hot;
      end
      if (rw_cmd && !burst_busy) begin
        burst_cnt_r   <= 2'(dcd_pkg::BURST_CLKS);
        O_BURST_WRITE <= (cmd == dcd_pkg::CMD_WRITE);
        O_BURST_BANK  <= p.ba;
      end else if (ck_rise && burst_busy) begin
        burst_cnt_r <= burst_cnt_r - 2'd1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // self-refresh exit read hold-off and status outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sr_exit_cnt_r <= 8'h00;
    end else if (sr_exit) begin
      sr_exit_cnt_r <= 8'(dcd_pkg::SR_EXIT_READ_CLKS);
    end else if (ck_rise && sr_exit_cnt_r != 8'h00) begin
      sr_exit_cnt_r <= sr_exit_cnt_r - 8'h01;
    end
  end

  wire in_pd = (state_nxt == dcd_pkg::ST_ACT_PD) || (state_nxt == dcd_pkg::ST_PRE_PD);
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_STATE               <= 3'd0;
      O_BANK_OPEN           <= '0;
      O_BURST_BUSY          <= 1'b0;
      O_REFRESH_PULSE       <= 1'b0;
      O_INTERNAL_REFRESH_EN <= 1'b0;
      O_ODT_AVAIL           <= 1'b1;
      O_DLL_ON              <= 1'b1;
      O_READ_ALLOWED        <= 1'b1;
    end else begin
      O_STATE               <= 3'(state_nxt);
      O_BANK_OPEN           <= bank_open_r;
      O_BURST_BUSY          <= burst_busy;
      O_REFRESH_PULSE       <= exec && cmd == dcd_pkg::CMD_REFRESH;
      O_INTERNAL_REFRESH_EN <= (state_nxt == dcd_pkg::ST_SELF_REF) && !in_pd;
      O_ODT_AVAIL           <= (state_nxt != dcd_pkg::ST_SELF_REF);
      O_DLL_ON              <= !(state_nxt == dcd_pkg::ST_PRE_PD ||
                                 state_nxt == dcd_pkg::ST_SELF_REF ||
                                 (state_nxt == dcd_pkg::ST_ACT_PD &&
                                  O_MODE_REG[dcd_pkg::PD_EXIT_BIT]));
      O_READ_ALLOWED        <= (sr_exit_cnt_r == 8'h00) && !sr_exit;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  property p_mode_one;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (mode_wr && p.ba == 2'b01) |=> (O_EXT_MODE_ONE == $past(p.addr));
  endproperty
  a_mode_one: assert property (p_mode_one) else $error("ext mode one not loaded");

  property p_mode_two;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (mode_wr && p.ba == 2'b10) |=> (O_EXT_MODE_TWO == $past(p.addr)) && $stable(O_MODE_REG);
  endproperty
  a_mode_two: assert property (p_mode_two) else $error("ext mode two wrong");

  property p_base_mode;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (mode_wr && p.ba == 2'b00) |=> (O_MODE_REG == $past(p.addr)) && $stable(O_EXT_MODE_ONE);
  endproperty
  a_base_mode: assert property (p_base_mode) else $error("base mode wrong");

  property p_act_pd;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (!in_sr && ck_rise && cke_fall && quiet && !all_idle &&
       state_r inside {dcd_pkg::ST_IDLE, dcd_pkg::ST_ACTIVE})
      |=> state_r == dcd_pkg::ST_ACT_PD;
  endproperty
  a_act_pd: assert property (p_act_pd) else $error("active powerdown missed");

  property p_pre_pd;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (ck_rise && cke_fall && quiet && all_idle &&
       state_r inside {dcd_pkg::ST_IDLE, dcd_pkg::ST_ACTIVE})
      |=> state_r == dcd_pkg::ST_PRE_PD;
  endproperty
  a_pre_pd: assert property (p_pre_pd) else $error("precharge powerdown missed");

  property p_sr_idle;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ($rose(state_r == dcd_pkg::ST_SELF_REF)) |-> $past(all_idle);
  endproperty
  a_sr_idle: assert property (p_sr_idle) else $error("self refresh with open bank");

  property p_sr_exit;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (in_sr && p.cke) |=> state_r == dcd_pkg::ST_IDLE ##1 !O_READ_ALLOWED;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit missed");

  property p_pd_hold;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (state_r == dcd_pkg::ST_PRE_PD && !p.cke) |=> state_r == dcd_pkg::ST_PRE_PD;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("powerdown left with cke low");

  property p_burst_run;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (burst_busy && rw_cmd) |=> $stable(O_BURST_BANK) && burst_cnt_r <= $past(burst_cnt_r);
  endproperty
  a_burst_run: assert property (p_burst_run) else $error("burst cut short");

  property p_no_refresh_pd;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      (state_r inside {dcd_pkg::ST_ACT_PD, dcd_pkg::ST_PRE_PD}) |=> !O_INTERNAL_REFRESH_EN;
  endproperty
  a_no_refresh_pd: assert property (p_no_refresh_pd) else $error("refresh in powerdown");

  property p_odt_sr;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      in_sr |-> !O_ODT_AVAIL;
  endproperty
  a_odt_sr: assert property (p_odt_sr) else $error("termination in self refresh");

endmodule // dcd_decoder

// ### tb/dcd_ctrl_model.sv
/*
  memory controller model: makes the memory clock and drives the command pins.
  assumes the bench paces requests through send and put only.
*/
`timescale 1ns/1ps

module dcd_ctrl_model (
  // system
  input  wire logic          i_clk,
  input  wire logic          i_run,
  // memory side
  output logic               o_ck,
  output dcd_pkg::dcd_pins_t o_pins
);

  // --------------------------------------------------------------
  // memory clock
  // --------------------------------------------------------------
  logic [1:0] ph_r;

  // deselect with clock-enable low until the bench starts the device
  initial begin
    o_ck   = 1'b0;
    ph_r   = 2'h0;
    o_pins = {4'hf, 1'b0, 1'b0, 2'h0, 14'h0000};
  end

  // eight system clocks a period; frozen while run is low, as in self refresh
  always @(posedge i_clk) begin
    #1;
    if (i_run) begin
      ph_r = ph_r + 2'h1;
      if (ph_r == 2'h0) o_ck = ~o_ck;
    end
  end

  // --------------------------------------------------------------
  // requests
  // --------------------------------------------------------------
  // pins change six clocks after a rise, so the slow sampler still sees them
  task automatic send(input dcd_pkg::dcd_pins_t p);
    @(posedge o_ck);
    repeat (6) @(posedge i_clk);
    #1 o_pins = p;
  endtask

  // drive without a memory clock, for the asynchronous exit
  task automatic put(input dcd_pkg::dcd_pins_t p);
    @(posedge i_clk);
    #1 o_pins = p;
  endtask

endmodule // dcd_ctrl_model

// ### tb/dcd_decoder_bench.sv
/*
  bench for the command decoder: sequences of controller commands with checks.
  assumes the controller model and a 40 MHz system clock.
*/
`timescale 1ns/1ps

module dcd_decoder_bench;

  // --------------------------------------------------------------
  // commands as cs ras cas we
  // --------------------------------------------------------------
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_DES = 4'hf;

  logic               clk   = 1'b0;
  logic               rst   = 1'b1;
  logic               run   = 1'b0;
  logic               odt_v = 1'b0;
  logic               mck;
  dcd_pkg::dcd_pins_t pins;
  logic [13:0]        mreg, ext1, ext2, row;
  logic [2:0]         st;
  logic [3:0]         bopen;
  logic [1:0]         bbank;
  logic               busy, bwr, refp, iref, odta, dll, rdok;
  int                 mismatches = 0;
  int                 n_compared = 0;
  int                 n_ref = 0;
  int                 r0;
  logic [13:0]        mv [3] = '{14'h1001, 14'h0044, 14'h0080};

  always #12.5 clk = ~clk;

  // refresh pulse lasts one cycle, so it is counted at every edge
  always @(posedge clk) if (refp === 1'b1) n_ref <= n_ref + 1;

  dcd_ctrl_model u_dcd_ctrl_model (.i_clk(clk), .i_run(run), .o_ck(mck), .o_pins(pins));

  dcd_decoder u_dcd_decoder (
    .I_CLK(clk), .I_SYS_RST(rst), .I_MEM_CK(mck), .I_CKE(pins.cke),
    .I_CS_N(pins.cs_n), .I_RAS_N(pins.ras_n), .I_CAS_N(pins.cas_n), .I_WE_N(pins.we_n),
    .I_ODT(pins.odt), .I_BA(pins.ba), .I_ADDR(pins.addr),
    .O_MODE_REG(mreg), .O_EXT_MODE_ONE(ext1), .O_EXT_MODE_TWO(ext2), .O_STATE(st),
    .O_BANK_OPEN(bopen), .O_ROW_ADDR(row), .O_BURST_BUSY(busy), .O_BURST_WRITE(bwr),
    .O_BURST_BANK(bbank), .O_REFRESH_PULSE(refp), .O_INTERNAL_REFRESH_EN(iref),
    .O_ODT_AVAIL(odta), .O_DLL_ON(dll), .O_READ_ALLOWED(rdok)
  );

  // --------------------------------------------------------------
  // access and compare tasks
  // --------------------------------------------------------------
  function automatic dcd_pkg::dcd_pins_t mk(input logic [3:0] c, input logic k,
                                            input logic [1:0] b, input logic [13:0] a);
    return {c, k, odt_v, b, a};
  endfunction

  // command then a nop; returns once the command's effect has settled
  task automatic cmd(input logic [3:0] c, input logic k, input logic [1:0] b,
                     input logic [13:0] a);
    u_dcd_ctrl_model.send(mk(c, k, b, a));
    u_dcd_ctrl_model.send(mk(C_NOP, k, 2'h0, 14'h0000));
  endtask

  task automatic chk_v(input string n, input logic [13:0] e, input logic [13:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_f(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_s(input dcd_pkg::dcd_state_t e);
    n_compared++;
    if (st !== e) begin
      mismatches++;
      $display("Error state expected %h seen %h", e, st);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk_v("mode", 14'h0000, mreg);
    chk_s(dcd_pkg::ST_IDLE);
    chk_f("odt_avail", 1'b1, odta);
    chk_f("read_ok", 1'b1, rdok);
    run = 1'b1;
    // first rise only records clock-enable
    cmd(C_DES, 1'b1, 2'h0, 14'h0000);
    $display("test reset done");
    // calibration bits stay clear; hot-refresh bit set in extended two
    for (int i = 0; i < 3; i++) cmd(C_MRS, 1'b1, 2'(i), mv[i]);
    chk_v("mode", mv[0], mreg);
    chk_v("ext1", mv[1], ext1);
    chk_v("ext2", mv[2], ext2);
    $display("test mode done");
    // termination pin held high must not disturb decoding
    odt_v = 1'b1;
    cmd(C_ACT, 1'b1, 2'h2, 14'h1234);
    chk_v("open", 14'h0004, 14'(bopen));
    chk_v("row", 14'h1234, row);
    chk_s(dcd_pkg::ST_ACTIVE);
    cmd(C_ACT, 1'b1, 2'h1, 14'h0abc);
    chk_v("open", 14'h0006, 14'(bopen));
    u_dcd_ctrl_model.send(mk(C_WR, 1'b1, 2'h2, 14'h0000));
    u_dcd_ctrl_model.send(mk(C_RD, 1'b1, 2'h1, 14'h0000));
    chk_f("busy", 1'b1, busy);
    chk_f("burst_write", 1'b1, bwr);
    u_dcd_ctrl_model.send(mk(C_NOP, 1'b1, 2'h0, 14'h0000));
    chk_f("burst_write", 1'b1, bwr);
    chk_v("burst_bank", 14'h0002, 14'(bbank));
    cmd(C_RD, 1'b1, 2'h2, 14'h0400);
    chk_f("burst_write", 1'b0, bwr);
    chk_v("open", 14'h0002, 14'(bopen));
    cmd(C_PRE, 1'b1, 2'h1, 14'h0000);
    chk_v("open", 14'h0000, 14'(bopen));
    cmd(C_ACT, 1'b1, 2'h0, 14'h0011);
    cmd(C_ACT, 1'b1, 2'h3, 14'h0022);
    cmd(C_WR, 1'b1, 2'h3, 14'h0400);
    chk_v("burst_bank", 14'h0003, 14'(bbank));
    chk_v("open", 14'h0001, 14'(bopen));
    cmd(C_PRE, 1'b1, 2'h2, 14'h0400);
    chk_v("open", 14'h0000, 14'(bopen));
    odt_v = 1'b0;
    $display("test bank done");
    r0 = n_ref;
    cmd(C_REF, 1'b1, 2'h0, 14'h0000);
    chk_v("refresh", 14'h0001, 14'(n_ref - r0));
    chk_f("busy", 1'b0, busy);
    // an unlisted encoding is ignored: no bank opens, no state change
    cmd(4'h6, 1'b1, 2'h1, 14'h0000);
    chk_v("open", 14'h0000, 14'(bopen));
    chk_s(dcd_pkg::ST_IDLE);
    $display("test refresh done");
    cmd(C_ACT, 1'b1, 2'h0, 14'h0011);
    cmd(C_NOP, 1'b0, 2'h0, 14'h0000);
    chk_s(dcd_pkg::ST_ACT_PD);
    chk_f("dll", 1'b0, dll);
    r0 = n_ref;
    // a command with clock-enable low must change nothing
    cmd(C_ACT, 1'b0, 2'h1, 14'h0000);
    chk_s(dcd_pkg::ST_ACT_PD);
    chk_v("open", 14'h0001, 14'(bopen));
    chk_v("refresh", 14'h0000, 14'(n_ref - r0));
    chk_f("int_refresh", 1'b0, iref);
    cmd(C_NOP, 1'b1, 2'h0, 14'h0000);
    chk_s(dcd_pkg::ST_ACTIVE);
    chk_f("dll", 1'b1, dll);
    cmd(C_PRE, 1'b1, 2'h0, 14'h0400);
    cmd(C_DES, 1'b0, 2'h0, 14'h0000);
    chk_s(dcd_pkg::ST_PRE_PD);
    chk_f("dll", 1'b0, dll);
    // clock-enable kept low and then high for at least three rises
    cmd(C_NOP, 1'b0, 2'h0, 14'h0000);
    cmd(C_DES, 1'b1, 2'h0, 14'h0000);
    chk_s(dcd_pkg::ST_IDLE);
    cmd(C_NOP, 1'b1, 2'h0, 14'h0000);
    $display("test powerdown done");
    odt_v = 1'b1;
    cmd(C_REF, 1'b0, 2'h0, 14'h0000);
    chk_s(dcd_pkg::ST_SELF_REF);
    chk_f("int_refresh", 1'b1, iref);
    chk_f("odt_avail", 1'b0, odta);
    cmd(C_DES, 1'b0, 2'h0, 14'h0000);
    // exit must be seen with the memory clock stopped
    run = 1'b0;
    u_dcd_ctrl_model.put(mk(C_NOP, 1'b1, 2'h0, 14'h0000));
    repeat (8) @(posedge clk);
    #1;
    chk_s(dcd_pkg::ST_IDLE);
    chk_f("read_ok", 1'b0, rdok);
    chk_f("odt_avail", 1'b1, odta);
    chk_f("int_refresh", 1'b0, iref);
    run = 1'b1;
    repeat (190) u_dcd_ctrl_model.send(mk(C_NOP, 1'b1, 2'h0, 14'h0000));
    chk_f("read_ok", 1'b0, rdok);
    repeat (20) u_dcd_ctrl_model.send(mk(C_NOP, 1'b1, 2'h0, 14'h0000));
    chk_f("read_ok", 1'b1, rdok);
    $display("test selfrefresh done");
    stop_test();
  end

  // tests take about 300 memory clocks (60 us); allow over three times that
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

endmodule // dcd_decoder_bench
